//--- pwmch_channel.sv
// Purpose: One PWM channel with buffered period, high time, run and polarity.
// Assumes: pwm_clk_in is asynchronous to aclk and well below aclk / 2.
// Notes:   Each rising edge of pwm_clk_in is one PWM count.
// Function
// R1: Sixteen-bit period sets cycle length in counts.
// R2: Period and high time writable halted or running.
// R3: Cycle start loads down-counters from buffered values.
// R4: Running writes take effect next cycle.
// R5: Reads return last written value, not counters.
// R6: Period in bits 15:0, upper reserved zero.
// R7: High time counts asserted output cycles.
// R8: Software keeps high time between one and period.
// R9: Period and high time reset to zero.
// R10: Run bit loads counters, starts next edge.
// R11: Polarity selects level of each phase.
// R12: Clearing run finishes current cycle then halts.
// R13: After reset channel halted, output low.
// R14: Run bit 0, bits 31:1 read zero.
// R15: Asserted phase first, then deasserted remainder.
// R16: Halted output follows polarity bit.
// R17: PWM clock edge synchronised before use.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module pwmch_channel (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address and data
   input  wire logic [11:0] s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   // AXI4-Lite read
   input  wire logic [11:0] s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // PWM pins
   input  wire logic        pwm_clk_in,
   output logic             pwm_out
);

   pwmch_pkg::pwmch_state_type st;
   pwmch_pkg::pwmch_state_type next_st;
   logic                       tick;
   logic                       wr_fire;

   // R17 edge from synchronised clock
   assign tick      = st.clk_s2 & ~st.clk_s3;
   assign wr_fire   = st.aw_got & st.w_got & ~st.bvalid;

   assign s_awready = ~st.aw_got & ~st.bvalid;
   assign s_wready  = ~st.w_got & ~st.bvalid;
   assign s_bvalid  = st.bvalid;
   assign s_bresp   = st.bresp;
   assign s_arready = ~st.rvalid;
   assign s_rvalid  = st.rvalid;
   assign s_rdata   = st.rdata;
   assign s_rresp   = st.rresp;
   assign pwm_out   = st.pwm_out;

   always_comb begin
      logic [15:0] load_p;
      logic [15:0] load_h;
      logic [15:0] cur_p;
      logic [15:0] cur_h;
      logic        active;
      load_p  = st.regs.period_value;
      load_h  = st.regs.high_time_value;
      cur_p   = st.cnt_period;
      cur_h   = st.cnt_high;
      active  = st.running;
      next_st = st;

      // R17 two-flop pin synchroniser
      next_st.clk_s1 = pwm_clk_in;
      next_st.clk_s2 = st.clk_s1;
      next_st.clk_s3 = st.clk_s2;

      // Address and data are taken independently, in either order
      if (s_awvalid && s_awready) begin
         next_st.aw_got = 1'b1;
         next_st.awaddr = s_awaddr;
      end
      if (s_wvalid && s_wready) begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_wdata;
         next_st.wstrb = s_wstrb;
      end

      // R2 writes accepted in any channel state
      if (wr_fire) begin
         next_st.aw_got = 1'b0;
         next_st.w_got  = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = pwmch_pkg::RESP_OKAY;
         // Partial-word writes are refused so a half-updated count never loads
         if (st.wstrb != pwmch_pkg::STRB_FULL) begin
            next_st.bresp = pwmch_pkg::RESP_SLVERR;
         end else begin
            case (st.awaddr)
               // R6 only the low sixteen bits are stored
               pwmch_pkg::OFS_PERIOD: begin
                  next_st.regs.period_value =
                     st.wdata[pwmch_pkg::VALUE_LSB +: pwmch_pkg::VALUE_W];
               end
               pwmch_pkg::OFS_HIGH_TIME: begin
                  next_st.regs.high_time_value =
                     st.wdata[pwmch_pkg::VALUE_LSB +: pwmch_pkg::VALUE_W];
               end
               // R14 run control in bit 0
               pwmch_pkg::OFS_RUN: begin
                  next_st.regs.channel_run = st.wdata[pwmch_pkg::RUN_BIT];
               end
               pwmch_pkg::OFS_POLARITY: begin
                  next_st.regs.polarity_flip = st.wdata[pwmch_pkg::POLARITY_BIT];
               end
               default: begin
                  next_st.bresp = pwmch_pkg::RESP_SLVERR;
               end
            endcase
         end
      end else if (st.bvalid && s_bready) begin
         next_st.bvalid = 1'b0;
      end

      // R5 reads return buffered values, never the counters
      if (s_arvalid && s_arready) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = pwmch_pkg::RESP_OKAY;
         next_st.rdata  = 32'h0000_0000;
         case (s_araddr)
            pwmch_pkg::OFS_PERIOD: begin
               next_st.rdata[15:0] = st.regs.period_value;
            end
            pwmch_pkg::OFS_HIGH_TIME: begin
               next_st.rdata[15:0] = st.regs.high_time_value;
            end
            // R14 upper bits read as zero
            pwmch_pkg::OFS_RUN: begin
               next_st.rdata[pwmch_pkg::RUN_BIT] = st.regs.channel_run;
            end
            pwmch_pkg::OFS_POLARITY: begin
               next_st.rdata[pwmch_pkg::POLARITY_BIT] = st.regs.polarity_flip;
            end
            default: begin
               next_st.rresp = pwmch_pkg::RESP_SLVERR;
            end
         endcase
      end else if (st.rvalid && s_rready) begin
         next_st.rvalid = 1'b0;
      end

      // Channel advances only on a PWM clock edge
      if (tick) begin
         // R3 R4 buffered values load only at a boundary
         if (st.cnt_period == pwmch_pkg::COUNT_ZERO) begin
            // R10 R12 start or halt only at a boundary
            active = st.regs.channel_run;
            // A zero period would wrap the period count to 16'hFFFF, so it runs as one count
            cur_p  = (load_p == pwmch_pkg::COUNT_ZERO) ? pwmch_pkg::COUNT_ONE : load_p;
            cur_h  = load_h;
            next_st.cur_pol = st.regs.polarity_flip;
         end
         next_st.running = active;
         if (active) begin
            // R7 R11 R15 asserted while high count remains
            next_st.pwm_out    = (cur_h != pwmch_pkg::COUNT_ZERO) ^ next_st.cur_pol;
            // R1 one count per PWM clock edge
            next_st.cnt_period = cur_p - pwmch_pkg::COUNT_ONE;
            next_st.cnt_high   = (cur_h != pwmch_pkg::COUNT_ZERO) ?
                                 cur_h - pwmch_pkg::COUNT_ONE : pwmch_pkg::COUNT_ZERO;
         end else begin
            // R16 halted level follows polarity
            next_st.pwm_out    = st.regs.polarity_flip;
            next_st.cnt_period = pwmch_pkg::COUNT_ZERO;
            next_st.cnt_high   = pwmch_pkg::COUNT_ZERO;
         end
      end
   end

   // R9 R13 everything clears, output low and halted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_start_edge;
      tick && st.cnt_period == 16'h0000 && st.regs.channel_run;
   endsequence

   sequence s_mid_cycle;
      tick && st.running && st.cnt_period != 16'h0000;
   endsequence

   sequence s_read_period;
      s_arvalid && s_arready && s_araddr == pwmch_pkg::OFS_PERIOD;
   endsequence

   sequence s_write_fire;
      st.aw_got && st.w_got && !st.bvalid;
   endsequence

   a_start_load: assert property ( // R10
      (s_start_edge and st.regs.period_value > 16'h0000) |=>
         st.running && st.cnt_period == $past(st.regs.period_value) - 16'h0001)
      else $error("channel did not load period on start");

   a_cycle_reload: assert property ( // R3
      s_start_edge |=> st.cur_pol == $past(st.regs.polarity_flip))
      else $error("polarity not captured at cycle start");

   a_finish_cycle: assert property ( // R12
      st.running && st.cnt_period != 16'h0000 |=> st.running)
      else $error("channel halted before cycle end");

   a_buffer_hold: assert property ( // R4
      st.running && st.cnt_period != 16'h0000 && !tick |=>
         $stable(st.cnt_period) && $stable(st.cnt_high) && $stable(st.cur_pol))
      else $error("running counters changed between edges");

   a_high_phase: assert property ( // R15
      (s_mid_cycle and st.cnt_high != 16'h0000) |=> pwm_out == !$past(st.cur_pol))
      else $error("output not asserted during high time");

   a_low_phase: assert property ( // R11
      (s_mid_cycle and st.cnt_high == 16'h0000) |=> pwm_out == $past(st.cur_pol))
      else $error("output not deasserted after high time");

   a_halt_level: assert property ( // R16
      tick && st.cnt_period == 16'h0000 && !st.regs.channel_run |=>
         !st.running && pwm_out == $past(st.regs.polarity_flip))
      else $error("halted output does not follow polarity");

   a_read_back: assert property ( // R5
      s_read_period |=> s_rvalid && s_rdata == {16'h0000, $past(st.regs.period_value)})
      else $error("period read did not return stored value");

   a_run_reserved: assert property ( // R14
      s_arvalid && s_arready && s_araddr == pwmch_pkg::OFS_RUN |=> s_rdata[31:1] == 31'h0)
      else $error("run register upper bits not zero");

   a_write_answer: assert property ( // R2
      st.aw_got && st.w_got && !st.bvalid |=> s_bvalid [*1] ##0 !s_awready)
      else $error("write response missing");

   // Reset state is checked on the first cycle after release
   a_reset_low: assert property ( // R13
      !$past(aresetn) |-> !pwm_out && !st.running)
      else $error("output not low and halted after reset");

   // Counts step once per synchronised edge
   a_high_load: assert property ( // R3
      (s_start_edge and st.regs.high_time_value != 16'h0000) |=>
         st.cnt_high == $past(st.regs.high_time_value) - 16'h0001)
      else $error("high count not loaded at cycle start");

   a_period_step: assert property ( // R1
      s_mid_cycle |=> st.cnt_period == $past(st.cnt_period) - 16'h0001)
      else $error("period count did not step by one");

   a_high_step: assert property ( // R7
      (s_mid_cycle and st.cnt_high != 16'h0000) |=>
         st.cnt_high == $past(st.cnt_high) - 16'h0001)
      else $error("high count did not step by one");

   a_halt_steady: assert property ( // R16
      !st.running && !tick |=> !st.running && $stable(pwm_out))
      else $error("halted channel moved between edges");

   // A refused write must leave every stored setting as it was
   a_refuse_strobe: assert property ( // R5
      (s_write_fire and st.wstrb != pwmch_pkg::STRB_FULL) |=>
         s_bresp == pwmch_pkg::RESP_SLVERR && $stable(st.regs))
      else $error("partial write not refused");

   a_write_clear: assert property ( // R2
      s_bvalid && s_bready |=> !s_bvalid)
      else $error("write response not released");

   a_read_answer: assert property ( // R5
      s_arvalid && s_arready |=> s_rvalid && !s_arready)
      else $error("read data missing");

   a_read_clear: assert property ( // R5
      s_rvalid && s_rready |=> !s_rvalid)
      else $error("read data not released");

endmodule : pwmch_channel

//--- pwmch_pkg.sv
// Purpose: Shared constants and types for the single PWM channel block.
// Assumes: AXI4-Lite register access with 32-bit data, one word per register.
// Notes:   The PWM input clock is sampled as an ordinary pin on aclk.
package pwmch_pkg;

   // Register map, byte addresses
   localparam int          ADDR_W          = 12;
   localparam logic [11:0] OFS_PERIOD      = 12'h000;
   localparam logic [11:0] OFS_HIGH_TIME   = 12'h004;
   localparam logic [11:0] OFS_RUN         = 12'h008;
   localparam logic [11:0] OFS_POLARITY    = 12'h00C;

   // Field layout
   localparam int          VALUE_W         = 16;
   localparam int          VALUE_LSB       = 0;
   localparam int          RUN_BIT         = 0;
   localparam int          POLARITY_BIT    = 0;

   // Reset values
   localparam logic [15:0] PERIOD_RESET    = 16'h0000;
   localparam logic [15:0] HIGH_TIME_RESET = 16'h0000;
   localparam logic        RUN_RESET       = 1'b0;
   localparam logic        POLARITY_RESET  = 1'b0;

   // Bus answers, full write strobe and count constants
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
   localparam logic [3:0]  STRB_FULL       = 4'hF;
   localparam logic [15:0] COUNT_ONE       = 16'h0001;
   localparam logic [15:0] COUNT_ZERO      = 16'h0000;

   // Software-visible buffered settings
   typedef struct packed {
      logic [15:0] period_value;
      logic [15:0] high_time_value;
      logic        channel_run;
      logic        polarity_flip;
   } pwmch_regs_type;

   // Complete state of the block
   typedef struct packed {
      pwmch_regs_type regs;
      logic        aw_got;
      logic [11:0] awaddr;
      logic        w_got;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        clk_s1;
      logic        clk_s2;
      logic        clk_s3;
      logic        running;
      logic [15:0] cnt_period;
      logic [15:0] cnt_high;
      logic        cur_pol;
      logic        pwm_out;
   } pwmch_state_type;

endpackage : pwmch_pkg

//--- pwmch_clk_model.sv
// Purpose: Far side of the channel: PWM count clock source and output load.
// Assumes: One requested count edge at a time; pin idles low between edges.
// Notes:   The load samples pwm_out once the edge has had time to act.
`timescale 1ns/1ps
module pwmch_clk_model (
   // Clock
   input  wire logic aclk,
   // Requests from the bench
   input  wire logic step,
   output logic      done,
   output logic      level,
   // Channel pins
   input  wire logic pwm_out,
   output logic      pwm_clk_in
);
   logic [3:0] cnt;

   initial begin
      cnt        = 4'h0;
      pwm_clk_in = 1'b0;
      done       = 1'b0;
      level      = 1'b0;
   end

   // High lasts four aclk periods and low at least five, above the two the sampler needs
   always_ff @(posedge aclk) begin
      done <= 1'b0;
      if (cnt == 4'h0) begin
         if (step) begin
            cnt        <= 4'h8;
            pwm_clk_in <= 1'b1;
         end
      end else begin
         cnt <= cnt - 4'h1;
         if (cnt == 4'h5) pwm_clk_in <= 1'b0;
         if (cnt == 4'h1) begin
            done  <= 1'b1;
            level <= pwm_out;
         end
      end
   end
endmodule : pwmch_clk_model

//--- pwm_channel_period_duty_enable_test.sv
// Purpose: Self-checking bench for the single PWM channel.
// Assumes: Count edges come one at a time from the clock model.
// Notes:   Each expected pattern lists output levels after each edge, first in bit 0.
`timescale 1ns/1ps
module pwm_channel_period_duty_enable_test;
   logic        aclk, aresetn, step, done, level, pwm_clk_in, pwm_out;
   logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic        s_arvalid, s_arready, s_rvalid, s_rready;
   logic [11:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata;
   logic [3:0]  s_wstrb;
   logic [1:0]  s_bresp, s_rresp;
   int          mismatches, total_checks;

   pwmch_channel pwmch_channel_inst (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
      .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
      .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .pwm_clk_in, .pwm_out);
   pwmch_clk_model pwmch_clk_model_inst (.aclk, .step, .done, .level, .pwm_out, .pwm_clk_in);

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
                     input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] r;
      s_awaddr <= a; s_wdata <= d; s_wstrb <= st;
      s_awvalid <= 1'b1; s_wvalid <= 1'b1; s_bready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge aclk);
         ta = s_awvalid && s_awready; tw = s_wvalid && s_wready; tb = s_bvalid; r = s_bresp;
         @(posedge aclk);
         if (ta) s_awvalid <= 1'b0;
         if (tw) s_wvalid <= 1'b0;
         if (tb) break;
      end
      s_bready <= 1'b0;
      cmp("bvalid", 32'h1, {31'h0, tb});
      cmp("bresp", {30'h0, er}, {30'h0, r});
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ta, tr;
      logic [1:0] r;
      logic [31:0] d;
      s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge aclk);
         ta = s_arvalid && s_arready; tr = s_rvalid; d = s_rdata; r = s_rresp;
         @(posedge aclk);
         if (ta) s_arvalid <= 1'b0;
         if (tr) break;
      end
      s_rready <= 1'b0;
      cmp("rvalid", 32'h1, {31'h0, tr});
      cmp("rdata", ed, d);
      cmp("rresp", {30'h0, er}, {30'h0, r});
      @(posedge aclk);
   endtask : rd

   // One count edge per bit; the load's sample is compared with the pattern
   task automatic pattern(input int n, input logic [15:0] bits);
      for (int i = 0; i < n; i++) begin
         step <= 1'b1;
         @(posedge aclk);
         step <= 1'b0;
         for (int k = 0; k < 20 && !done; k++) @(posedge aclk);
         cmp("done", 32'h1, {31'h0, done});
         cmp("pwm_out", {31'h0, bits[i]}, {31'h0, level});
         @(posedge aclk);
      end
   endtask : pattern

   task automatic t_reset;
      for (int i = 0; i < 4; i++) rd(12'(4 * i), 32'h0, pwmch_pkg::RESP_OKAY);
      cmp("pwm_out", 32'h0, {31'h0, pwm_out});
      $display("test reset done");
   endtask : t_reset

   task automatic t_regs;
      wr(pwmch_pkg::OFS_PERIOD, 32'h0000ABCD, 4'hF, pwmch_pkg::RESP_OKAY);
      rd(pwmch_pkg::OFS_PERIOD, 32'h0000ABCD, pwmch_pkg::RESP_OKAY);
      wr(pwmch_pkg::OFS_PERIOD, 32'h00001111, 4'h3, pwmch_pkg::RESP_SLVERR);
      wr(12'h010, 32'h00000001, 4'hF, pwmch_pkg::RESP_SLVERR);
      rd(pwmch_pkg::OFS_PERIOD, 32'h0000ABCD, pwmch_pkg::RESP_OKAY);
      wr(pwmch_pkg::OFS_HIGH_TIME, 32'h00001234, 4'hF, pwmch_pkg::RESP_OKAY);
      rd(pwmch_pkg::OFS_HIGH_TIME, 32'h00001234, pwmch_pkg::RESP_OKAY);
      rd(12'h010, 32'h0, pwmch_pkg::RESP_SLVERR);
      $display("test registers done");
   endtask : t_regs

   task automatic t_wave;
      wr(pwmch_pkg::OFS_PERIOD, 32'h5, 4'hF, pwmch_pkg::RESP_OKAY);
      wr(pwmch_pkg::OFS_HIGH_TIME, 32'h2, 4'hF, pwmch_pkg::RESP_OKAY);
      wr(pwmch_pkg::OFS_RUN, 32'h1, 4'hF, pwmch_pkg::RESP_OKAY);
      pattern(11, 16'h0463);
      wr(pwmch_pkg::OFS_PERIOD, 32'h3, 4'hF, pwmch_pkg::RESP_OKAY);
      wr(pwmch_pkg::OFS_HIGH_TIME, 32'h2, 4'hF, pwmch_pkg::RESP_OKAY);
      // Old cycle spends its last four counts before the new values load
      pattern(5, 16'h0011);
      wr(pwmch_pkg::OFS_RUN, 32'h0, 4'hF, pwmch_pkg::RESP_OKAY);
      // One high count is still owed when run clears, so the first edge stays high
      pattern(3, 16'h0001);
      $display("test waveform done");
   endtask : t_wave

   task automatic t_pol;
      wr(pwmch_pkg::OFS_POLARITY, 32'h1, 4'hF, pwmch_pkg::RESP_OKAY);
      pattern(1, 16'h0001);
      wr(pwmch_pkg::OFS_RUN, 32'h1, 4'hF, pwmch_pkg::RESP_OKAY);
      rd(pwmch_pkg::OFS_RUN, 32'h1, pwmch_pkg::RESP_OKAY);
      pattern(7, 16'h0024);
      wr(pwmch_pkg::OFS_RUN, 32'h0, 4'hF, pwmch_pkg::RESP_OKAY);
      pattern(4, 16'h000E);
      $display("test polarity done");
   endtask : t_pol

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   initial begin
      mismatches = 0; total_checks = 0; aresetn = 1'b0; step = 1'b0;
      s_awaddr = 12'h0; s_awvalid = 1'b0; s_wdata = 32'h0; s_wstrb = 4'h0; s_wvalid = 1'b0;
      s_bready = 1'b0; s_araddr = 12'h0; s_arvalid = 1'b0; s_rready = 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_regs();
      t_wave();
      t_pol();
      wrap_up();
   end

   // Whole run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      wrap_up();
   end
endmodule : pwm_channel_period_duty_enable_test
